// ### hw/cexs_addr_check.sv
`timescale 1ns/10ps
module cexs_addr_check
  import cexs_pkg::*;
(
  // Instruction fetch
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_in_periph,
  input wire logic fetch_in_external,
  // Data access
  input wire logic data_valid,
  input wire logic data_master_cpu,
  input wire logic [31:0] data_addr,
  input wire logic [1:0] data_size,
  input wire logic data_in_periph,
  input wire logic data_periph_8bit,
  input wire logic data_in_external,
  // Mode and results
  input wire logic single_chip,
  output logic cpu_error,
  output logic dma_error
);
  logic fetch_err;
  logic misaligned;
  logic periph_bad;
  logic data_err;

  always_comb begin
    fetch_err = fetch_valid & (fetch_addr[0] | fetch_in_periph |
                               (fetch_in_external & single_chip)); // RULE_19
    misaligned = ((data_size == SZ_WORD) & data_addr[0]) |
                 ((data_size == SZ_LONG) & (data_addr[1:0] != 2'h0)); // RULE_20
    // A 16-bit module splits a longword into two halves, an 8-bit one cannot.
    periph_bad = data_in_periph & data_periph_8bit & (data_size == SZ_LONG); // RULE_21
    data_err = data_valid & (misaligned | periph_bad |
                             (data_in_external & single_chip)); // RULE_21
    cpu_error = fetch_err | (data_err & data_master_cpu);
    dma_error = data_err & ~data_master_cpu;
  end
endmodule

// ### hw/cexs_pkg.sv
// How it works
// [RULE_01] Resets, address errors, interrupts, instructions by priority.
// [RULE_02] Power-on rising edge starts reset processing.
// [RULE_03] Manual reset starts when its pin rises.
// [RULE_04] Address errors, interrupts wait for instruction end.
// [RULE_05] Trap starts on execution with its vector.
// [RULE_06] Undefined code outside slot: general illegal.
// [RULE_07] Undefined or PC-writing slot code: slot illegal.
// [RULE_08] Reset vectors at 0/4 or 8/12.
// [RULE_09] Reset clears base, sets mask to ones.
// [RULE_10] Others push status, PC, then fetch handler.
// [RULE_11] Only interrupts write the mask field.
// [RULE_12] Vector address is base plus number times four.
// [RULE_13] Each source has its own vector number.
// [RULE_14] Power-on also resets peripherals; manual does not.
// [RULE_15] Reset pins held low twenty cycles minimum.
// [RULE_16] Manual reset waits for bus cycle end.
// [RULE_17] Manual reset held for longest bus cycle.
// [RULE_18] Manual reset leaves bus state unit running.
// [RULE_19] Odd, peripheral or forbidden external fetch faults.
// [RULE_20] Misaligned word or longword access faults.
// [RULE_21] Peripheral longword to 8-bit, forbidden external faults.
// [RULE_22] Address error ends cycle, saves next PC.
package cexs_pkg;
  localparam logic [7:0] VEC_POR_PC = 8'h00;
  localparam logic [7:0] VEC_MR_PC = 8'h02;
  localparam logic [7:0] VEC_GEN_ILL = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
  localparam logic [7:0] VEC_CPU_ADDR = 8'h09;
  localparam logic [7:0] VEC_DMA_ADDR = 8'h0a;
  localparam logic [7:0] VEC_NMI = 8'h0b;
  localparam logic [7:0] VEC_BREAK = 8'h0c;
  localparam logic [7:0] VEC_TRAP_LO = 8'h20;
  localparam logic [7:0] VEC_IRQ_LO = 8'h40;
  localparam logic [7:0] VEC_PERIPH_LO = 8'h48;
  localparam int VEC_SHIFT = 2;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam int RESET_MIN_CYCLES = 20;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_POR_HOLD, ST_MR_HOLD, ST_FETCH_PC, ST_FETCH_SP,
    ST_PUSH_SR, ST_PUSH_PC, ST_FETCH_VEC
  } cexs_state_t;
endpackage

// ### hw/cexs_seq.sv
`timescale 1ns/10ps
module cexs_seq
  import cexs_pkg::*;
#(
  parameter int ADDR_W = 32
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset pins
  input wire logic power_on_reset_pin_n,
  input wire logic manual_reset_pin_n,
  // Decode pipeline
  input wire logic decode_valid,
  input wire logic insn_done,
  input wire logic decode_in_slot,
  input wire logic decode_undefined,
  input wire logic decode_pc_write,
  input wire logic trap_exec,
  input wire logic [7:0] trap_vector,
  input wire logic [31:0] status_word,
  input wire logic [31:0] save_pc,
  input wire logic [31:0] stack_register,
  input wire logic vbr_wr,
  input wire logic [31:0] vbr_wdata,
  // Interrupt request
  input wire logic irq_req,
  input wire logic [3:0] irq_level,
  input wire logic [7:0] irq_vector,
  // Bus accesses to be checked
  input wire logic bus_busy,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_in_periph,
  input wire logic fetch_in_external,
  input wire logic data_valid,
  input wire logic data_master_cpu,
  input wire logic [31:0] data_addr,
  input wire logic [1:0] data_size,
  input wire logic data_in_periph,
  input wire logic data_periph_8bit,
  input wire logic data_in_external,
  input wire logic single_chip,
  // Memory port for vector fetch and stacking
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Results
  output logic load_pc,
  output logic [31:0] pc_value,
  output logic load_sp,
  output logic [31:0] sp_value,
  output logic [31:0] vector_base,
  output logic mask_wr,
  output logic [3:0] interrupt_mask_field,
  output logic irq_ack,
  output logic bus_cycle_end,
  output logic cpu_init,
  output logic periph_init,
  output logic exc_busy
);
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_width
    $error("ADDR_W must lie between 10 and 32");
  end

  cexs_state_t state_q, state_d;
  logic pend_cpu_q, pend_cpu_d, pend_dma_q, pend_dma_d;
  logic [7:0] vec_q, vec_d;
  logic is_irq_q, is_irq_d;
  logic [3:0] level_q, level_d;
  logic [31:0] sp_q, sp_d, pc_q, pc_d, sp_out_q, sp_out_d, vbr_q, vbr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic req_q, req_d, we_q, we_d;
  logic lpc_q, lpc_d, lsp_q, lsp_d, mwr_q, mwr_d, ack_q, ack_d;
  logic [3:0] mask_q, mask_d;
  logic bend_q, bend_d, cinit_q, cinit_d, pinit_q, pinit_d;
  logic cpu_err, dma_err, ae_cpu, ae_dma, take;
  logic busy_q, busy_d;

  cexs_addr_check u_check (
    .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr),
    .fetch_in_periph(fetch_in_periph),
    .fetch_in_external(fetch_in_external),
    .data_valid(data_valid),
    .data_master_cpu(data_master_cpu),
    .data_addr(data_addr),
    .data_size(data_size),
    .data_in_periph(data_in_periph),
    .data_periph_8bit(data_periph_8bit),
    .data_in_external(data_in_external),
    .single_chip(single_chip),
    .cpu_error(cpu_err),
    .dma_error(dma_err)
  );

  function automatic logic [ADDR_W-1:0] vaddr(input logic [31:0] base, input logic [7:0] v);
    logic [31:0] sum;
    sum = base + {22'h0, v, 2'h0};
    return sum[ADDR_W-1:0];
  endfunction

  always_comb begin
    state_d = state_q;
    vec_d = vec_q;
    is_irq_d = is_irq_q;
    level_d = level_q;
    sp_d = sp_q;
    pc_d = pc_q;
    sp_out_d = sp_out_q;
    vbr_d = vbr_q;
    wdata_d = wdata_q;
    addr_d = addr_q;
    req_d = req_q;
    we_d = we_q;
    mask_d = mask_q;
    lpc_d = 1'b0;
    lsp_d = 1'b0;
    mwr_d = 1'b0;
    ack_d = 1'b0;
    cinit_d = 1'b0;
    pinit_d = 1'b0;
    // The faulting cycle is cut short one cycle later, by the registered bus_cycle_end; entry waits for the instruction.
    bend_d = cpu_err | dma_err; // RULE_22
    ae_cpu = pend_cpu_q | cpu_err;
    ae_dma = pend_dma_q | dma_err;
    pend_cpu_d = ae_cpu;
    pend_dma_d = ae_dma;
    take = decode_valid & insn_done; // RULE_04
    if (!power_on_reset_pin_n) begin
      state_d = ST_POR_HOLD;
      cinit_d = 1'b1;
      pinit_d = 1'b1; // RULE_14
      req_d = 1'b0;
      pend_cpu_d = 1'b0;
      pend_dma_d = 1'b0;
    end else if (!manual_reset_pin_n && state_q != ST_POR_HOLD) begin
      // Peripherals and the bus state unit keep running, so refresh goes on.
      state_d = ST_MR_HOLD; // RULE_03
      cinit_d = 1'b1; // RULE_18
      req_d = req_q & ~mem_ack; // RULE_16
      pend_cpu_d = 1'b0;
      pend_dma_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_POR_HOLD: begin
          state_d = ST_FETCH_PC; // RULE_02
          vec_d = VEC_POR_PC;
          addr_d = vaddr(32'h0, VEC_POR_PC); // RULE_08
          req_d = 1'b1;
          we_d = 1'b0;
        end
        ST_MR_HOLD: begin
          req_d = req_q & ~mem_ack;
          // Our own access or someone else's bus cycle must end before entry.
          if (!bus_busy && !req_q) begin // RULE_16
            state_d = ST_FETCH_PC; // RULE_03
            vec_d = VEC_MR_PC;
            addr_d = vaddr(32'h0, VEC_MR_PC); // RULE_08
            req_d = 1'b1;
            we_d = 1'b0;
          end
        end
        ST_FETCH_PC: begin
          if (mem_ack) begin
            pc_d = mem_rdata;
            addr_d = addr_q + WORD_STEP[ADDR_W-1:0]; // RULE_08
            state_d = ST_FETCH_SP;
          end
        end
        ST_FETCH_SP: begin
          if (mem_ack) begin
            sp_out_d = mem_rdata;
            req_d = 1'b0;
            lpc_d = 1'b1;
            lsp_d = 1'b1;
            vbr_d = VBR_RESET; // RULE_09
            mask_d = MASK_RESET; // RULE_09
            mwr_d = 1'b1;
            state_d = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (vbr_wr) begin
            vbr_d = vbr_wdata;
          end
          state_d = ST_PUSH_SR;
          is_irq_d = 1'b0;
          // Fixed order: address errors, interrupt, trap, illegal codes.
          if (take && ae_cpu) begin // RULE_01
            vec_d = VEC_CPU_ADDR; // RULE_13
            // A new fault in the cycle that takes an older one stays pending.
            pend_cpu_d = pend_cpu_q & cpu_err;
          end else if (take && ae_dma) begin // RULE_01
            vec_d = VEC_DMA_ADDR; // RULE_13
            pend_dma_d = pend_dma_q & dma_err;
          end else if (take && irq_req) begin // RULE_01
            vec_d = irq_vector; // RULE_13
            level_d = irq_level;
            is_irq_d = 1'b1;
            ack_d = 1'b1;
          end else if (trap_exec) begin // RULE_05
            vec_d = trap_vector;
          end else if (decode_valid && decode_in_slot &&
                       (decode_undefined || decode_pc_write)) begin // RULE_07
            vec_d = VEC_SLOT_ILL;
          end else if (decode_valid && decode_undefined) begin // RULE_06
            vec_d = VEC_GEN_ILL;
          end else begin
            state_d = ST_IDLE;
          end
          if (state_d == ST_PUSH_SR) begin
            // The pipeline presents the resume address for this source.
            pc_d = save_pc; // RULE_22
            sp_d = stack_register - WORD_STEP; // RULE_10
            addr_d = vaddr(stack_register - WORD_STEP, 8'h00);
            wdata_d = status_word;
            req_d = 1'b1;
            we_d = 1'b1;
          end
        end
        ST_PUSH_SR: begin
          if (mem_ack) begin
            sp_d = sp_q - WORD_STEP; // RULE_10
            addr_d = vaddr(sp_q - WORD_STEP, 8'h00);
            wdata_d = pc_q;
            state_d = ST_PUSH_PC;
          end
        end
        ST_PUSH_PC: begin
          if (mem_ack) begin
            addr_d = vaddr(vbr_q, vec_q); // RULE_12
            we_d = 1'b0;
            state_d = ST_FETCH_VEC;
          end
        end
        ST_FETCH_VEC: begin
          if (mem_ack) begin
            pc_d = mem_rdata; // RULE_10
            sp_out_d = sp_q;
            req_d = 1'b0;
            lpc_d = 1'b1;
            lsp_d = 1'b1;
            mwr_d = is_irq_q; // RULE_11
            if (is_irq_q) begin
              mask_d = level_q; // RULE_11
            end
            state_d = ST_IDLE;
          end
        end
      endcase
    end
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_POR_HOLD;
      pend_cpu_q <= 1'b0;
      pend_dma_q <= 1'b0;
      vec_q <= 8'h00;
      is_irq_q <= 1'b0;
      level_q <= 4'h0;
      sp_q <= 32'h0;
      pc_q <= 32'h0;
      sp_out_q <= 32'h0;
      vbr_q <= VBR_RESET;
      wdata_q <= 32'h0;
      addr_q <= '0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      mask_q <= MASK_RESET;
      lpc_q <= 1'b0;
      lsp_q <= 1'b0;
      mwr_q <= 1'b0;
      ack_q <= 1'b0;
      bend_q <= 1'b0;
      cinit_q <= 1'b1;
      pinit_q <= 1'b1;
      busy_q <= 1'b1;
    end else begin
      state_q <= state_d;
      pend_cpu_q <= pend_cpu_d;
      pend_dma_q <= pend_dma_d;
      vec_q <= vec_d;
      is_irq_q <= is_irq_d;
      level_q <= level_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      sp_out_q <= sp_out_d;
      vbr_q <= vbr_d;
      wdata_q <= wdata_d;
      addr_q <= addr_d;
      req_q <= req_d;
      we_q <= we_d;
      mask_q <= mask_d;
      lpc_q <= lpc_d;
      lsp_q <= lsp_d;
      mwr_q <= mwr_d;
      ack_q <= ack_d;
      bend_q <= bend_d;
      cinit_q <= cinit_d;
      pinit_q <= pinit_d;
      busy_q <= busy_d;
    end
  end

  assign mem_req = req_q;
  assign mem_we = we_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign load_pc = lpc_q;
  assign pc_value = pc_q;
  assign load_sp = lsp_q;
  assign sp_value = sp_out_q;
  assign vector_base = vbr_q;
  assign mask_wr = mwr_q;
  assign interrupt_mask_field = mask_q;
  assign irq_ack = ack_q;
  assign bus_cycle_end = bend_q;
  assign cpu_init = cinit_q;
  assign periph_init = pinit_q;
  assign exc_busy = busy_q;

  property p_por_init;
    @(posedge clk) disable iff (rst)
      !power_on_reset_pin_n |=> state_q == ST_POR_HOLD && periph_init && cpu_init;
  endproperty
  a_por_init: assert property (p_por_init) else $error("power-on hold wrong"); // RULE_14

  property p_mr_keeps_periph;
    @(posedge clk) disable iff (rst)
      power_on_reset_pin_n && !manual_reset_pin_n && state_q != ST_POR_HOLD
      |=> cpu_init && !periph_init;
  endproperty
  a_mr_keeps_periph: assert property (p_mr_keeps_periph) else $error("manual reset hit periph"); // RULE_18

  property p_mr_waits;
    @(posedge clk) disable iff (rst)
      state_q == ST_MR_HOLD && bus_busy |=> state_q != ST_FETCH_PC;
  endproperty
  a_mr_waits: assert property (p_mr_waits) else $error("manual entry during bus cycle"); // RULE_16

  property p_por_vec;
    @(posedge clk) disable iff (rst)
      state_q == ST_POR_HOLD && power_on_reset_pin_n
      |=> mem_req && !mem_we && mem_addr == '0 && state_q == ST_FETCH_PC;
  endproperty
  a_por_vec: assert property (p_por_vec) else $error("power-on vector fetch wrong"); // RULE_08

  property p_reset_end;
    @(posedge clk) disable iff (rst)
      state_q == ST_FETCH_SP && mem_ack && power_on_reset_pin_n && manual_reset_pin_n
      |=> load_pc && load_sp && vector_base == VBR_RESET
          && interrupt_mask_field == MASK_RESET && sp_value == $past(mem_rdata);
  endproperty
  a_reset_end: assert property (p_reset_end) else $error("reset entry end wrong"); // RULE_09

  property p_push_pc;
    @(posedge clk) disable iff (rst)
      state_q == ST_PUSH_SR && mem_ack && power_on_reset_pin_n && manual_reset_pin_n
      |=> mem_we && mem_wdata == pc_q && mem_addr == sp_q[ADDR_W-1:0];
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pc push wrong"); // RULE_10

  property p_vec_addr;
    @(posedge clk) disable iff (rst)
      state_q == ST_FETCH_VEC |-> mem_addr == vaddr(vbr_q, vec_q) && !mem_we;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // RULE_12

  property p_irq_mask;
    @(posedge clk) disable iff (rst)
      state_q == ST_FETCH_VEC && mem_ack && power_on_reset_pin_n && manual_reset_pin_n
      |=> mask_wr == $past(is_irq_q) && (!mask_wr || interrupt_mask_field == $past(level_q));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("mask update wrong"); // RULE_11

  property p_ae_first;
    @(posedge clk) disable iff (rst)
      state_q == ST_IDLE && decode_valid && insn_done && pend_cpu_q && irq_req
      && power_on_reset_pin_n && manual_reset_pin_n
      |=> vec_q == VEC_CPU_ADDR && !irq_ack;
  endproperty
  a_ae_first: assert property (p_ae_first) else $error("priority wrong"); // RULE_01

  property p_bus_end;
    @(posedge clk) disable iff (rst)
      cpu_err || dma_err |=> bus_cycle_end;
  endproperty
  a_bus_end: assert property (p_bus_end) else $error("faulting cycle not ended"); // RULE_22
endmodule

// ### test/cexs_mem_model.sv
`timescale 1ns/10ps
module cexs_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Wait states before each acknowledge
  input wire logic [3:0] wait_cycles
);
  logic [3:0] cnt_q;
  logic lw[$];
  logic [31:0] la[$];
  logic [31:0] ld[$];
  // Read data is the inverted address, so every fetched vector is predictable.
  // Outside the acknowledge cycle the data toggles, so a sample one cycle late never matches.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'h0;
      cnt_q <= 4'h0;
      mem_rdata <= 32'h5a5a_a5a5;
    end else begin
      if (mem_req && mem_ack) begin
        lw.push_back(mem_we);
        la.push_back(mem_addr);
        ld.push_back(mem_wdata);
      end
      if (mem_req && !mem_ack && cnt_q >= wait_cycles) begin
        mem_ack <= 1'h1;
        cnt_q <= 4'h0;
        mem_rdata <= ~mem_addr;
      end else begin
        mem_ack <= 1'h0;
        cnt_q <= (mem_req && !mem_ack) ? cnt_q + 4'h1 : 4'h0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule

// ### test/test_cpu_exception_sequencer.sv
`timescale 1ns/10ps
module test_cpu_exception_sequencer;
  import cexs_pkg::*;
  logic clk, rst, power_on_reset_pin_n, manual_reset_pin_n, bus_busy, vbr_wr;
  logic decode_valid, insn_done, decode_in_slot, decode_undefined, decode_pc_write, trap_exec;
  logic irq_req, fetch_valid, fetch_in_periph, fetch_in_external, data_valid, data_master_cpu;
  logic data_in_periph, data_periph_8bit, data_in_external, single_chip;
  logic [7:0] trap_vector, irq_vector;
  logic [3:0] irq_level, wait_cycles, mask_before, interrupt_mask_field;
  logic [1:0] data_size;
  logic [31:0] status_word, save_pc, stack_register, vbr_wdata, fetch_addr, data_addr, vb_exp;
  logic mem_req, mem_we, mem_ack, load_pc, load_sp, mask_wr, irq_ack, bus_cycle_end;
  logic cpu_init, periph_init, exc_busy;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, pc_value, sp_value, vector_base;
  int errors = 0;
  int n_compared = 0;

  cexs_seq uut (.*);
  cexs_mem_model mem (.*);

  always #2.5 clk = ~clk;

  task automatic results;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic clear_log;
    mem.la.delete();
    mem.lw.delete();
    mem.ld.delete();
  endtask

  task automatic wait_load;
    for (int i = 0; i < 60 && load_pc !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic reset_seq(input logic [31:0] base);
    wait_load();
    chk_word("reset log", 32'h2, 32'(mem.la.size()));
    if (mem.la.size() == 2) begin
      chk_word("pc slot", base, mem.la[0]);
      chk_word("sp slot", base + WORD_STEP, mem.la[1]);
    end
    chk_word("pc_value", ~base, pc_value);
    chk_word("sp_value", ~(base + WORD_STEP), sp_value);
    chk_bit("load_sp", 1'h1, load_sp);
    chk_bit("reset mask_wr", 1'h1, mask_wr);
    chk_word("vector_base", 32'h0, vector_base);
    chk_word("mask", 32'hf, {28'h0, interrupt_mask_field});
    vb_exp = 32'h0;
    repeat (2) @(posedge clk);
  endtask

  // Only decode_valid and the interrupt request stand during the hold cycles.
  task automatic pulse_dec(input logic [3:0] k, input logic [7:0] tv, input logic irq,
                           input logic [3:0] lvl, input logic [7:0] iv, input int hold);
    clear_log();
    mask_before = interrupt_mask_field;
    @(posedge clk);
    decode_valid <= 1'h1;
    {irq_req, irq_level, irq_vector} <= {irq, lvl, iv};
    for (int i = 0; i < hold; i++) begin
      #1;
      chk_bit("early exc_busy", 1'h0, exc_busy);
      @(posedge clk);
    end
    insn_done <= 1'h1;
    {decode_in_slot, decode_undefined, decode_pc_write, trap_exec} <= k;
    trap_vector <= tv;
    @(posedge clk);
    {decode_valid, insn_done, decode_in_slot, decode_undefined} <= 4'h0;
    {decode_pc_write, trap_exec, irq_req} <= 3'h0;
    #1;
  endtask

  task automatic finish_exc(input logic [7:0] vec, input logic is_irq, input logic [3:0] lvl);
    logic [31:0] h;
    h = vb_exp + {22'h0, vec, 2'h0};
    chk_bit("irq_ack", is_irq, irq_ack);
    chk_bit("exc_busy", 1'h1, exc_busy);
    wait_load();
    chk_word("entry log", 32'h3, 32'(mem.la.size()));
    if (mem.la.size() == 3) begin
      chk_word("kinds", 32'h6, {29'h0, mem.lw[0], mem.lw[1], mem.lw[2]});
      chk_word("sr addr", stack_register - 32'h4, mem.la[0]);
      chk_word("sr data", status_word, mem.ld[0]);
      chk_word("pc addr", stack_register - 32'h8, mem.la[1]);
      chk_word("pc data", save_pc, mem.ld[1]);
      chk_word("vec addr", h, mem.la[2]);
    end
    chk_word("pc_value", ~h, pc_value);
    chk_word("sp_value", stack_register - 32'h8, sp_value);
    chk_bit("mask_wr", is_irq, mask_wr);
    chk_word("mask", {28'h0, is_irq ? lvl : mask_before}, {28'h0, interrupt_mask_field});
    repeat (2) @(posedge clk);
  endtask

  // Mode bits m: peripheral, 8-bit module, external, single chip, CPU master.
  task automatic acc(input logic f, input logic [31:0] a, input logic [1:0] sz,
                     input logic [4:0] m, input logic [7:0] vec);
    @(posedge clk);
    {fetch_valid, data_valid, fetch_addr, data_addr, data_size} <= {f, !f, a, a, sz};
    {fetch_in_periph, data_periph_8bit, fetch_in_external, single_chip, data_master_cpu} <= m;
    {data_in_periph, data_in_external} <= {m[4], m[2]};
    @(posedge clk);
    {fetch_valid, data_valid} <= 2'h0;
    #1;
    chk_bit("bus_cycle_end", vec != 8'h0, bus_cycle_end);
    if (vec != 8'h0) begin
      pulse_dec(4'h0, 8'h0, 1'h1, 4'h3, 8'h50, 0);
      finish_exc(vec, 1'h0, 4'h0);
    end
  endtask

  initial begin
    {clk, rst, power_on_reset_pin_n, manual_reset_pin_n, bus_busy, vbr_wr} = 6'h14;
    {decode_valid, insn_done, decode_in_slot, decode_undefined, decode_pc_write} = 5'h0;
    {trap_exec, irq_req, fetch_valid, fetch_in_periph, fetch_in_external, data_valid} = 6'h0;
    {data_master_cpu, data_in_periph, data_periph_8bit, data_in_external, single_chip} = 5'h0;
    {trap_vector, irq_vector, irq_level, wait_cycles, data_size} = 26'h0;
    {vbr_wdata, fetch_addr, data_addr, vb_exp} = 128'h0;
    {status_word, save_pc, stack_register} = {32'h0000_00f0, 32'h0000_2222, 32'h0000_1000};
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    repeat (20) @(posedge clk);
    #1;
    chk_bit("cpu_init", 1'h1, cpu_init);
    chk_bit("periph_init", 1'h1, periph_init);
    clear_log();
    @(posedge clk);
    power_on_reset_pin_n <= 1'h1;
    reset_seq(32'h0);
    @(posedge clk);
    {vbr_wr, vbr_wdata} <= {1'h1, 32'h0000_4000};
    vb_exp = 32'h0000_4000;
    @(posedge clk);
    vbr_wr <= 1'h0;
    pulse_dec(4'h1, 8'h21, 1'h0, 4'h0, 8'h0, 0);
    finish_exc(8'h21, 1'h0, 4'h0);
    pulse_dec(4'h4, 8'h0, 1'h0, 4'h0, 8'h0, 0);
    finish_exc(VEC_GEN_ILL, 1'h0, 4'h0);
    pulse_dec(4'hc, 8'h0, 1'h0, 4'h0, 8'h0, 0);
    finish_exc(VEC_SLOT_ILL, 1'h0, 4'h0);
    pulse_dec(4'ha, 8'h0, 1'h0, 4'h0, 8'h0, 0);
    finish_exc(VEC_SLOT_ILL, 1'h0, 4'h0);
    pulse_dec(4'hd, 8'h22, 1'h0, 4'h0, 8'h0, 0);
    finish_exc(8'h22, 1'h0, 4'h0);
    pulse_dec(4'h0, 8'h0, 1'h1, 4'h5, VEC_IRQ_LO, 3);
    finish_exc(VEC_IRQ_LO, 1'h1, 4'h5);
    pulse_dec(4'h1, 8'h3f, 1'h1, 4'h9, 8'h47, 0);
    finish_exc(8'h47, 1'h1, 4'h9);
    pulse_dec(4'h0, 8'h0, 1'h1, 4'hf, VEC_NMI, 0);
    finish_exc(VEC_NMI, 1'h1, 4'hf);
    wait_cycles <= 4'h3;
    acc(1'h1, 32'h0000_1001, SZ_WORD, 5'h01, VEC_CPU_ADDR);
    acc(1'h1, 32'hffff_8000, SZ_WORD, 5'h11, VEC_CPU_ADDR);
    acc(1'h1, 32'h0040_0000, SZ_WORD, 5'h07, VEC_CPU_ADDR);
    acc(1'h1, 32'h0040_0000, SZ_WORD, 5'h05, 8'h0);
    acc(1'h1, 32'h0000_1002, SZ_WORD, 5'h01, 8'h0);
    acc(1'h0, 32'h0000_2001, SZ_WORD, 5'h00, VEC_DMA_ADDR);
    acc(1'h0, 32'h0000_2001, SZ_BYTE, 5'h00, 8'h0);
    acc(1'h0, 32'h0000_2002, SZ_LONG, 5'h01, VEC_CPU_ADDR);
    acc(1'h0, 32'h0000_2004, SZ_LONG, 5'h01, 8'h0);
    acc(1'h0, 32'hffff_8004, SZ_LONG, 5'h19, VEC_CPU_ADDR);
    acc(1'h0, 32'hffff_8004, SZ_LONG, 5'h11, 8'h0);
    acc(1'h0, 32'hffff_8001, SZ_BYTE, 5'h19, 8'h0);
    acc(1'h0, 32'h0040_0000, SZ_WORD, 5'h06, VEC_DMA_ADDR);
    @(posedge clk);
    {bus_busy, manual_reset_pin_n, single_chip} <= 3'h4;
    repeat (3) @(posedge clk);
    #1;
    chk_bit("cpu_init busy", 1'h1, cpu_init);
    repeat (20) @(posedge clk);
    #1;
    chk_bit("cpu_init", 1'h1, cpu_init);
    chk_bit("periph_init", 1'h0, periph_init);
    clear_log();
    @(posedge clk);
    manual_reset_pin_n <= 1'h1;
    // The other master's cycle still runs, so entry must hold off.
    repeat (4) @(posedge clk);
    #1;
    chk_bit("mem_req busy", 1'h0, mem_req);
    chk_bit("exc_busy hold", 1'h1, exc_busy);
    @(posedge clk);
    bus_busy <= 1'h0;
    reset_seq(32'h8);
    pulse_dec(4'h1, 8'h3f, 1'h0, 4'h0, 8'h0, 0);
    finish_exc(8'h3f, 1'h0, 4'h0);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("mismatch watchdog expected end seen timeout");
    results();
  end
endmodule
